/* File: shared/twt_pkg.sv */
// Constants, register map and types of the two-wire target transmitter
`default_nettype none
package twt_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_ADDR = 8'h0C;
	localparam logic [7:0] OFS_ISTS = 8'h10;
	localparam logic [7:0] OFS_IMSK = 8'h14;
	// Control bit positions
	localparam int B_FLAG  = 7;
	localparam int B_ACKEN = 6;
	localparam int B_STA   = 5;
	localparam int B_STO   = 4;
	localparam int B_WC    = 3;
	localparam int B_EN    = 2;
	localparam int B_IE    = 0;
	// Event status bit positions
	localparam int I_STEP = 0;
	localparam int I_WAKE = 1;
	// Status codes
	localparam logic [7:0] ST_A8 = 8'hA8;
	localparam logic [7:0] ST_B0 = 8'hB0;
	localparam logic [7:0] ST_B8 = 8'hB8;
	localparam logic [7:0] ST_C0 = 8'hC0;
	localparam logic [7:0] ST_C8 = 8'hC8;
	localparam logic [7:0] ST_F8 = 8'hF8;
	// Reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_ADDR = 8'h00;
	localparam logic [7:0] RST_DATA = 8'hFF;
	localparam logic [1:0] RST_PRESC = 2'h0;
	localparam logic [1:0] RST_IMSK = 2'h0;
	// Bit counts
	localparam logic [3:0] LAST_BIT = 4'h7;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_ADDR = 7'h02,
		S_AACK = 7'h04,
		S_WAIT = 7'h08,
		S_TX   = 7'h10,
		S_DACK = 7'h20,
		S_POST = 7'h40
	} twt_state_e;

	typedef struct packed {
		twt_state_e  st;
		logic [7:0]  ctrl;
		logic [1:0]  presc;
		logic [7:0]  code;
		logic [7:0]  data;
		logic [7:0]  own;
		logic [7:0]  sh;
		logic [3:0]  cnt;
		logic        last;
		logic        mack;
		logic        arb;
		logic        busy;
		logic [1:0]  ists;
		logic [1:0]  imsk;
		logic        scl_s1;
		logic        scl_s2;
		logic        scl_p;
		logic        sda_s1;
		logic        sda_s2;
		logic        sda_p;
		logic        scl_oe;
		logic        sda_oe;
		logic        scl_o;
		logic        sda_o;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
		logic        step_irq;
		logic        wake;
		logic        start_pls;
	} twt_regs_s;
endpackage
`default_nettype wire

/* File: hw/twt_target_tx.sv */
// Two-wire target transmitter with APB registers, event interrupt and wake request
`default_nettype none
module twt_target_tx
	import twt_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Two-wire bus, open drain
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	// System side
	input  wire logic        deep_sleep,
	input  wire logic        arb_lost,
	output logic             wake_req,
	output logic             start_req_pulse,
	output logic             step_irq,
	output logic             irq
);
	twt_regs_s q;
	twt_regs_s n;
	logic [7:0] stat_v;

	function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] own);
		addr_hit = (b[7:1] == own[7:1]) || ((b[7:1] == 7'h00) && own[0]);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_DATA) ||
			(a == OFS_ADDR) || (a == OFS_ISTS) || (a == OFS_IMSK);
	endfunction

	// Code field shows F8 while the flag is clear
	assign stat_v = {(q.ctrl[B_FLAG] ? q.code[7:3] : ST_F8[7:3]), 1'b0, q.presc};

	always_comb begin
		logic scl_r;
		logic scl_f;
		logic st_c;
		logic sp_c;
		logic set_f;
		logic clr_f;
		logic wr;
		logic rd;
		logic setup;
		logic [7:0] b8;
		logic [31:0] rv;
		scl_r = 1'b0;
		scl_f = 1'b0;
		st_c = 1'b0;
		sp_c = 1'b0;
		set_f = 1'b0;
		clr_f = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		setup = 1'b0;
		b8 = 8'h00;
		rv = 32'h0000_0000;
		n = q;
		n.start_pls = 1'b0;
		// Synchronisers and edge history
		n.scl_s1 = scl_i;
		n.scl_s2 = q.scl_s1;
		n.scl_p = q.scl_s2;
		n.sda_s1 = sda_i;
		n.sda_s2 = q.sda_s1;
		n.sda_p = q.sda_s2;
		scl_r = q.scl_s2 & ~q.scl_p;
		scl_f = ~q.scl_s2 & q.scl_p;
		st_c = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
		sp_c = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
		wr = psel & penable & pwrite & q.pready;
		rd = psel & penable & ~pwrite & q.pready;
		setup = psel & ~penable;
		b8 = {q.sh[6:0], q.sda_s2};
		if (st_c) begin
			n.busy = 1'b1;
		end else if (sp_c) begin
			n.busy = 1'b0;
		end
		if (arb_lost) begin
			n.arb = 1'b1;
		end

		unique case (q.st)
			S_IDLE: begin
			end
			S_ADDR: begin
				// Bits keep shifting even while ack enable is off, but no address is recognised then
				if (scl_r) begin
					n.sh = b8;
					n.cnt = q.cnt + 4'h1;
					if (q.cnt == LAST_BIT) begin
						if (q.ctrl[B_EN] && q.ctrl[B_ACKEN] && b8[0] && addr_hit(b8, q.own)) begin
							n.st = S_AACK;
						end else begin
							n.st = S_IDLE;
						end
					end
				end
			end
			S_AACK: begin
				if (scl_f) begin
					if (!q.sda_oe) begin
						n.sda_oe = 1'b1;
					end else begin
						n.sda_oe = 1'b0;
						n.scl_oe = 1'b1;
						set_f = 1'b1;
						n.code = q.arb ? ST_B0 : ST_A8;
						n.arb = 1'b0;
						n.st = S_WAIT;
						if (deep_sleep) begin
							n.wake = 1'b1;
						end
					end
				end
			end
			S_WAIT: begin
			end
			S_TX: begin
				if (scl_f) begin
					if (q.cnt == LAST_BIT) begin
						n.sda_oe = 1'b0;
						n.st = S_DACK;
					end else begin
						n.sh = {q.sh[6:0], 1'b0};
						n.sda_oe = ~q.sh[6];
						n.cnt = q.cnt + 4'h1;
					end
				end
			end
			S_DACK: begin
				if (scl_r) begin
					n.mack = ~q.sda_s2;
				end
				if (scl_f) begin
					set_f = 1'b1;
					if (!q.mack) begin
						n.code = ST_C0;
						n.st = S_POST;
					end else if (q.last) begin
						n.code = ST_C8;
						n.st = S_POST;
					end else begin
						n.code = ST_B8;
						n.scl_oe = 1'b1;
						n.st = S_WAIT;
					end
				end
			end
			S_POST: begin
				// Master may keep clocking; the data line stays released
				n.sda_oe = 1'b0;
			end
			default: begin
				n.st = S_IDLE;
			end
		endcase

		// START and STOP seen on the bus
		if (st_c && (q.st != S_WAIT)) begin
			n.st = S_ADDR;
			n.cnt = 4'h0;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
		end else if (sp_c && (q.st != S_WAIT) && (q.st != S_POST)) begin
			n.st = S_IDLE;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
			n.arb = 1'b0;
		end

		// Register writes
		if (wr) begin
			unique case (paddr)
				OFS_CTRL: begin
					n.ctrl[B_ACKEN] = pwdata[B_ACKEN];
					n.ctrl[B_STA] = pwdata[B_STA];
					n.ctrl[B_STO] = pwdata[B_STO];
					n.ctrl[B_EN] = pwdata[B_EN];
					n.ctrl[B_IE] = pwdata[B_IE];
					clr_f = pwdata[B_FLAG];
					if (pwdata[B_FLAG] && q.ctrl[B_FLAG]) begin
						n.wake = 1'b0;
						if (q.st == S_WAIT && pwdata[B_STO]) begin
							n.st = S_IDLE;
							n.scl_oe = 1'b0;
							n.ctrl[B_STO] = 1'b0;
						end else if (q.st == S_WAIT) begin
							n.last = ~pwdata[B_ACKEN];
							n.sh = q.data;
							n.sda_oe = ~q.data[7];
							n.scl_oe = 1'b0;
							n.cnt = 4'h0;
							n.st = S_TX;
						end else if (q.st == S_POST) begin
							n.st = S_IDLE;
						end
					end
				end
				OFS_STAT: begin
					n.presc = pwdata[1:0];
				end
				OFS_DATA: begin
					// Only software fills the data register
					if (q.ctrl[B_FLAG]) begin
						n.data = pwdata[7:0];
						n.ctrl[B_WC] = 1'b0;
					end else begin
						n.ctrl[B_WC] = 1'b1;
					end
				end
				OFS_ADDR: begin
					n.own = pwdata[7:0];
				end
				OFS_IMSK: begin
					n.imsk = pwdata[1:0];
				end
				default: begin
				end
			endcase
		end

		// Hardware set wins over a software clear
		n.ctrl[B_FLAG] = set_f | (q.ctrl[B_FLAG] & ~clr_f);
		n.ctrl[1] = 1'b0;

		if (!n.ctrl[B_EN]) begin
			n.st = S_IDLE;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
			n.wake = 1'b0;
		end

		// START request served once the bus is free and nothing is pending
		if (q.ctrl[B_STA] && !q.busy && (q.st == S_IDLE) && !q.ctrl[B_FLAG] && q.ctrl[B_EN]) begin
			n.start_pls = 1'b1;
			n.ctrl[B_STA] = 1'b0;
		end

		// Sticky events, cleared by a read, new events win
		if (rd && (paddr == OFS_ISTS)) begin
			n.ists = 2'h0;
		end
		n.ists[I_STEP] = n.ists[I_STEP] | set_f;
		n.ists[I_WAKE] = n.ists[I_WAKE] | (n.wake & ~q.wake);
		n.irq = |(n.ists & n.imsk);
		n.step_irq = n.ctrl[B_FLAG] & n.ctrl[B_IE];

		// APB answer prepared in the setup cycle
		unique case (paddr)
			OFS_CTRL: rv = {24'h000000, q.ctrl};
			OFS_STAT: rv = {24'h000000, stat_v};
			OFS_DATA: rv = {24'h000000, q.data};
			OFS_ADDR: rv = {24'h000000, q.own};
			OFS_ISTS: rv = {30'h0, q.ists};
			OFS_IMSK: rv = {30'h0, q.imsk};
			default: rv = 32'h0000_0000;
		endcase
		n.pready = setup;
		n.pslverr = setup & ~mapped(paddr);
		n.prdata = (setup && !pwrite) ? rv : 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.st <= S_IDLE;
			q.ctrl <= RST_CTRL;
			q.own <= RST_ADDR;
			q.data <= RST_DATA;
			q.presc <= RST_PRESC;
			q.imsk <= RST_IMSK;
			q.code <= ST_F8;
			q.scl_s1 <= 1'b1;
			q.scl_s2 <= 1'b1;
			q.scl_p <= 1'b1;
			q.sda_s1 <= 1'b1;
			q.sda_s2 <= 1'b1;
			q.sda_p <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign scl_o = q.scl_o;
	assign scl_oe = q.scl_oe;
	assign sda_o = q.sda_o;
	assign sda_oe = q.sda_oe;
	assign wake_req = q.wake;
	assign start_req_pulse = q.start_pls;
	assign step_irq = q.step_irq;
	assign irq = q.irq;

	// Software flag clear that no START overrides in the same cycle
	logic st_seen;
	logic wr_clr_flag;
	assign st_seen = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
	assign wr_clr_flag = psel & penable & pwrite & q.pready & (paddr == OFS_CTRL) & pwdata[B_FLAG] & pwdata[B_EN]
		& q.ctrl[B_FLAG] & ~(st_seen);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_flag_clr_wait;
		(q.st == S_WAIT) ##1 (q.st == S_TX);
	endsequence

	sequence s_addr_done;
		(q.st == S_ADDR) ##1 (q.st == S_AACK);
	endsequence

	chk_idle_status_f8: assert property (!q.ctrl[B_FLAG] |-> stat_v[7:3] == 5'h1F)
		else $error("status not F8 with flag clear");
	chk_addr_match: assert property (s_addr_done |-> q.sh[0] && addr_hit(q.sh, q.own) && q.ctrl[B_ACKEN])
		else $error("address accepted without a match");
	chk_ack_off_ignore: assert property ((q.st == S_ADDR) && !q.ctrl[B_ACKEN] |=> q.st != S_AACK)
		else $error("address acknowledged with ack enable off");
	chk_a8_b0_code: assert property ($past(q.st) == S_AACK && q.st == S_WAIT |->
		q.ctrl[B_FLAG] && q.scl_oe && (q.code == ($past(q.arb) ? ST_B0 : ST_A8)))
		else $error("wrong code after address acknowledge");
	chk_b0_arb: assert property ($rose(q.ctrl[B_FLAG]) && q.code == ST_B0 |-> $past(q.arb, 1))
		else $error("B0 without lost arbitration");
	chk_b8_stretch: assert property ($rose(q.ctrl[B_FLAG]) && q.code == ST_B8 |-> q.scl_oe && $past(q.mack))
		else $error("B8 without ack or clock hold");
	chk_tx_first_bit: assert property (s_flag_clr_wait |-> (q.sda_oe == ~q.sh[7]) && !q.scl_oe)
		else $error("first data bit not driven after flag clear");
	chk_c0_nack: assert property ($rose(q.ctrl[B_FLAG]) && q.code == ST_C0 |-> !$past(q.mack) && q.st == S_POST)
		else $error("C0 without NACK");
	chk_c8_final: assert property ($rose(q.ctrl[B_FLAG]) && q.code == ST_C8 |-> q.last && $past(q.mack))
		else $error("C8 without final byte ack");
	chk_post_quiet: assert property (q.st == S_POST |=> !q.sda_oe && !q.scl_oe)
		else $error("line driven after final byte");
	chk_wake_hold: assert property (q.wake |-> q.ctrl[B_FLAG] && (q.scl_oe || q.st != S_WAIT))
		else $error("wake request without flag or clock hold");
	chk_post_release: assert property ((q.st == S_POST) && wr_clr_flag |=> q.st == S_IDLE)
		else $error("no return to unaddressed state");
	chk_step_irq: assert property (q.ctrl[B_FLAG] && q.ctrl[B_IE] && $stable(q.ctrl) |-> ##[0:1] q.step_irq)
		else $error("step interrupt missing");
endmodule
`default_nettype wire

/* File: verification/twt_bus_master.sv */
// Behavioural two-wire bus master that reads from the target
`default_nettype none
module twt_bus_master (
	// Clock and resolved lines
	input  wire logic pclk,
	input  wire logic scl,
	input  wire logic sda,
	// Open-drain pulls, high pulls the line low
	output logic      scl_oe,
	output logic      sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	// Half of the 160 ns bus period
	task automatic hp();
		repeat (16) @(posedge pclk);
	endtask
	// Waits out clock stretching by the target, samples late in the high phase
	task automatic bit_io(input logic b, output logic s);
		sda_oe <= ~b;
		hp();
		scl_oe <= 1'b0;
		do @(posedge pclk); while (scl !== 1'b1);
		hp();
		s = sda;
		scl_oe <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic start();
		sda_oe <= 1'b1;
		hp();
		scl_oe <= 1'b1;
		hp();
	endtask
	task automatic stop();
		sda_oe <= 1'b1;
		hp();
		scl_oe <= 1'b0;
		do @(posedge pclk); while (scl !== 1'b1);
		hp();
		sda_oe <= 1'b0;
		hp();
	endtask
	task automatic send(input logic [7:0] v, output logic ack_n);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(v[i], s);
		bit_io(1'b1, ack_n);
	endtask
	// Ack low asks for more data, high ends the read
	task automatic recv(input logic nack, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
		bit_io(nack, s);
	endtask
endmodule
`default_nettype wire

/* File: verification/twt_target_tx_tb.sv */
// Bench for the two-wire target transmitter
`default_nettype none
module twt_target_tx_tb
	import twt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, a;
	logic        deep_sleep, arb_lost, wake_req, step_irq, irq, scl_oe, sda_oe, m_scl, m_sda, sreq;
	logic [7:0]  paddr, v;
	logic [31:0] pwdata, prdata, r;
	int          bad_count = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          sreq_count = 0;
	// Pull-ups: a line is low while any party pulls it
	wire         scl = ~(scl_oe | m_scl);
	wire         sda = ~(sda_oe | m_sda);

	twt_target_tx dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
		.deep_sleep(deep_sleep), .arb_lost(arb_lost), .wake_req(wake_req), .start_req_pulse(sreq),
		.step_irq(step_irq), .irq(irq));
	twt_bus_master far (.pclk(pclk), .scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	// Counts served start requests
	always @(posedge pclk) begin
		if (sreq === 1'b1) begin
			sreq_count <= sreq_count + 1;
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rv);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		apb(1'b1, ad, {24'h0, d}, r);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] rv);
		apb(1'b0, ad, 32'h0, rv);
	endtask
	task automatic wait_flag(input logic [7:0] x);
		int n;
		n = 0;
		do begin
			rd(OFS_CTRL, r);
			n++;
		end while (r[B_FLAG] !== 1'b1 && n < 3000);
		rd(OFS_STAT, r);
		chk("status", {24'h0, r[7:0] & 8'hF8}, {24'h0, x});
	endtask

	initial begin
		{psel, penable, pwrite, deep_sleep, arb_lost} = '0;
		paddr = '0;
		pwdata = '0;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_CTRL, r);
		chk("ctrl", r, {24'h0, RST_CTRL});
		rd(OFS_STAT, r);
		chk("status idle", r, {24'h0, ST_F8});
		rd(OFS_DATA, r);
		chk("data", r, {24'h0, RST_DATA});
		rd(OFS_ADDR, r);
		chk("own addr", r, {24'h0, RST_ADDR});
		rd(8'h18, r);
		chk("unmapped", {r[30:0], e}, 32'h1);
		wr(OFS_DATA, 8'h12);
		rd(OFS_CTRL, r);
		chk("collision", r, 32'h08);
		rd(OFS_DATA, r);
		chk("data guarded", r, {24'h0, RST_DATA});
		wr(OFS_STAT, 8'h03);
		rd(OFS_STAT, r);
		chk("prescaler", r, 32'hFB);
		$display("test reset done");
		wr(OFS_ADDR, 8'hB5);
		wr(OFS_IMSK, 8'h01);
		wr(OFS_CTRL, 8'h45);
		for (int i = 0; i < 2; i++) begin
			arb_lost <= i[0];
			@(posedge pclk);
			arb_lost <= 1'b0;
			far.start();
			far.send(8'hB5, a);
			chk("addr ack", {31'h0, a}, 32'h0);
			wait_flag(i ? ST_B0 : ST_A8);
			chk("irq", {30'h0, irq, step_irq}, 32'h3);
			rd(OFS_ISTS, r);
			chk("events", r & 32'h1, 32'h1);
			repeat (2) @(posedge pclk);
			chk("irq cleared", {31'h0, irq}, 32'h0);
			wr(OFS_DATA, 8'h3C ^ {8{i[0]}});
			wr(OFS_CTRL, 8'hC5);
			repeat (2) @(posedge pclk);
			chk("step irq", {31'h0, step_irq}, 32'h0);
			far.recv(1'b0, v);
			chk("byte1", {24'h0, v}, {24'h0, 8'h3C ^ {8{i[0]}}});
			wait_flag(ST_B8);
			wr(OFS_DATA, 8'hA5);
			wr(OFS_CTRL, i ? 8'hC5 : 8'h85);
			far.recv(i[0], v);
			chk("byte2", {24'h0, v}, 32'hA5);
			wait_flag(i ? ST_C0 : ST_C8);
			wr(OFS_CTRL, i ? 8'h85 : 8'hC5);
			far.recv(1'b1, v);
			chk("after last", {24'h0, v}, 32'hFF);
			far.stop();
			$display("test round %0d done", i);
		end
		far.start();
		far.send(8'hB5, a);
		chk("ignored addr", {31'h0, a}, 32'h1);
		far.stop();
		wr(OFS_CTRL, 8'h45);
		deep_sleep <= 1'b1;
		far.start();
		far.send(8'h01, a);
		chk("gc ack", {31'h0, a}, 32'h0);
		wait_flag(ST_A8);
		chk("wake hold", {30'h0, wake_req, scl_oe}, 32'h3);
		rd(OFS_ISTS, r);
		chk("wake event", r, 32'h3);
		wr(OFS_CTRL, 8'hD5);
		repeat (2) @(posedge pclk);
		chk("wake release", {30'h0, wake_req, scl_oe}, 32'h0);
		rd(OFS_CTRL, r);
		chk("stop cleared", r, 32'h45);
		rd(OFS_DATA, r);
		chk("data kept", r, 32'hA5);
		far.stop();
		deep_sleep <= 1'b0;
		$display("test wake done");
		wr(OFS_CTRL, 8'h65);
		repeat (3) @(posedge pclk);
		chk("start served", sreq_count, 32'h1);
		rd(OFS_CTRL, r);
		chk("start cleared", r, 32'h45);
		$display("test start request done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
